// File: mie_core.v
// instruction fetch, decode and execute core with apb control registers
//
// Overview of operation
// RULE1: instructions are single 14-bit words: opcode plus operand fields.
// RULE2: byte ops send the result to accumulator when d is 0, file when 1.
// RULE3: the file address is a 7-bit field selecting registers 0 to 0x7f.
// RULE4: literals are 8 bits, or 11 bits for jump and call.
// RULE5: one instruction cycle is four clock phases.
// RULE6: one cycle per instruction; skips and jumps add a no-operation cycle.
// RULE7: any file op reads the register before writing the result back.
// RULE8: bit-test skips the next instruction when the bit is one.
// RULE9: watchdog clear zeroes counter and prescaler, sets both active-low flags.
// RULE10: call pushes pc plus one, loads k and latch bits 4:3 into pc.
// RULE11: complement writes the inverse to the chosen destination, updates zero.
// RULE12: clear-file writes zero to the register and sets zero flag.
// RULE13: decrement subtracts one, sends to chosen destination, updates zero.
// RULE14: clear-accumulator loads zero into the accumulator and sets zero flag.
// RULE15: zero flag for complement and decrement follows an all-zero result.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "mie_defines.vh"
module mie_core (
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg  [12:0] prog_addr_o,
    input  wire [13:0] prog_data_i,
    output reg         wdog_timeout_o
);
    // ****************************************************************
    // state and registers
    // ****************************************************************
    localparam PH_FETCH  = 2'd0;
    localparam PH_DECODE = 2'd1;
    localparam PH_READ   = 2'd2;
    localparam PH_EXEC   = 2'd3;

    reg  [1:0]  phase_reg;
    reg  [13:0] instr_reg;
    reg         bubble_reg;
    reg  [12:0] program_counter_reg;
    reg  [4:0]  pc_upper_latch_reg;
    reg  [7:0]  accum_reg;
    reg         zero_reg;
    reg         timeout_flag_n_reg;
    reg         powerdown_flag_n_reg;
    reg         run_reg;
    reg         wden_reg;
    reg  [6:0]  faddr_reg;
    reg  [2:0]  sp_reg;
    reg  [12:0] stack_reg [0:`MIE_STACK_DEPTH-1];
    reg         wdclr_reg;

    wire [7:0]  file_rdata;
    wire [7:0]  wdog_count;
    wire [7:0]  wdog_prescale;
    wire        wdog_timeout;
    // the stack pointer wraps, so a ninth call overwrites the oldest entry
    wire [12:0] stack_top = stack_reg[sp_reg - 3'd1];

    // ****************************************************************
    // operand fields and decode
    // ****************************************************************
    // slices of the latched word; the opcode bits never reach the datapath
    wire [6:0]  f_fld   = instr_reg[`MIE_F_MSB:0];                  // RULE3
    wire        d_fld   = instr_reg[`MIE_D_POS];
    wire [2:0]  b_fld   = instr_reg[`MIE_B_MSB:`MIE_B_LSB];
    wire [10:0] k11_fld = instr_reg[`MIE_K11_MSB:0];                // RULE4
    wire [7:0]  k8_fld  = instr_reg[`MIE_K8_MSB:0];                 // RULE4

    // opcode portion compared under per-format masks; watchdog clear matches the whole word
    wire watchdog_clear_op  = (instr_reg == `MIE_WDCLR_WORD);       // RULE1
    wire clear_accum_op     = ((instr_reg & `MIE_MASK_CLR) == `MIE_CLEAR_ACCUM_OP_PAT);
    wire clear_reg_op       = ((instr_reg & `MIE_MASK_CLR) == `MIE_CLEAR_REG_OP_PAT);
    wire complement_reg_op  = ((instr_reg & `MIE_MASK_BYTE) == `MIE_COMPLEMENT_REG_OP_PAT);
    wire decrement_reg_op   = ((instr_reg & `MIE_MASK_BYTE) == `MIE_DECREMENT_REG_OP_PAT);
    wire skip_if_bit_one    = ((instr_reg & `MIE_MASK_BIT) == `MIE_BTSS_PAT);
    wire call_op            = ((instr_reg & `MIE_MASK_JMP) == `MIE_CALL_PAT);
    wire goto_op            = ((instr_reg & `MIE_MASK_JMP) == `MIE_GOTO_PAT);

    // ****************************************************************
    // execute datapath
    // ****************************************************************
    reg  [7:0]  result;
    reg         file_we;
    reg         accum_we;
    reg         zero_we;
    reg         zero_val;
    reg         take_bubble;

    // result, destination and zero flag for the byte operations
    always @* begin
        result      = 8'h00;
        file_we     = 1'b0;
        accum_we    = 1'b0;
        zero_we     = 1'b0;
        zero_val    = 1'b0;
        take_bubble = 1'b0;
        if (clear_accum_op) begin
            accum_we = 1'b1;                                        // RULE14
            zero_we  = 1'b1;
            zero_val = 1'b1;
        end else if (clear_reg_op) begin
            file_we  = 1'b1;                                        // RULE12
            zero_we  = 1'b1;
            zero_val = 1'b1;
        end else if (complement_reg_op || decrement_reg_op) begin
            if (complement_reg_op) begin
                result = ~file_rdata;                               // RULE11
            end else begin
                result = file_rdata - 8'h01;                        // RULE13
            end
            file_we  = d_fld;                                       // RULE2
            accum_we = ~d_fld;                                      // RULE2
            zero_we  = 1'b1;
            zero_val = (result == 8'h00);                           // RULE15
        end else if (skip_if_bit_one) begin
            take_bubble = file_rdata[b_fld];                        // RULE8
        end else if (call_op || goto_op) begin
            take_bubble = 1'b1;                                     // RULE6
        end
    end

    // execute strobe and the decoded apb write enables
    wire        exec_now = run_reg && (phase_reg == PH_EXEC);
    wire        core_we  = exec_now && file_we;
    wire        apb_acc  = psel_i && penable_i && pready_o;
    wire        apb_wr   = apb_acc && pwrite_i;
    wire        apb_fwr  = apb_wr && !run_reg && (paddr_i == `MIE_A_FDATA);
    // the file port belongs to software only while the core is stopped
    wire [6:0]  rd_addr  = run_reg ? f_fld : faddr_reg;             // RULE7
    wire [6:0]  wr_addr  = run_reg ? f_fld : faddr_reg;
    wire [7:0]  wr_data  = run_reg ? result : pwdata_i[7:0];

    // 128-byte file array with a registered read port
    mie_regfile u_regfile (
        .mclk_i    (mclk_i),
        .rd_addr_i (rd_addr),
        .rd_data_o (file_rdata),
        .wr_en_i   (core_we || apb_fwr),
        .wr_addr_i (wr_addr),
        .wr_data_i (wr_data)
    );

    // watchdog runs from the control enable and the one-clock clear pulse
    mie_watchdog u_watchdog (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .enable_i   (wden_reg),
        .clear_i    (wdclr_reg),
        .count_o    (wdog_count),
        .prescale_o (wdog_prescale),
        .timeout_o  (wdog_timeout)
    );

    // ****************************************************************
    // four phase sequencer: fetch, decode, file read, execute
    // ****************************************************************
    // the fetch address leaves on the phase-0 edge and the word is taken one
    // clock later, so program memory gets a full cycle to answer
    always @(posedge mclk_i) begin
        wdclr_reg <= 1'b0;
        if (rst_i) begin
            phase_reg           <= PH_FETCH;
            instr_reg           <= `MIE_NOP_WORD;
            bubble_reg          <= 1'b0;
            program_counter_reg <= `MIE_RST_PC;
            prog_addr_o         <= `MIE_RST_PC;
            accum_reg           <= `MIE_RST_BYTE;
            zero_reg            <= 1'b0;
            sp_reg              <= 3'd0;
        end else if (!run_reg) begin
            // a stopped core drops any pending no-operation slot, so the next
            // start fetches its first word without a stale bubble
            phase_reg  <= PH_FETCH;
            bubble_reg <= 1'b0;                                     // RULE6
            if (apb_wr && paddr_i == `MIE_A_PC) begin
                program_counter_reg <= pwdata_i[12:0];
            end
            if (apb_wr && paddr_i == `MIE_A_ACCUM) begin
                accum_reg <= pwdata_i[7:0];
            end
        end else begin
            phase_reg <= phase_reg + 2'd1;                          // RULE5
            case (phase_reg)
                PH_FETCH: begin
                    // present the fetch address for this instruction cycle
                    prog_addr_o <= program_counter_reg;
                end
                PH_DECODE: begin
                    // a bubble cycle runs as no-operation; the word at the fetch address is dropped and the pc holds
                    if (bubble_reg) begin
                        instr_reg <= `MIE_NOP_WORD;                 // RULE6
                    end else begin
                        instr_reg           <= prog_data_i;         // RULE1
                        program_counter_reg <= program_counter_reg + 13'd1;
                    end
                end
                PH_READ: begin
                    instr_reg <= instr_reg;                         // file read under way
                end
                PH_EXEC: begin
                    // results, flags and program counter change on the closing edge
                    bubble_reg <= take_bubble;                      // RULE6
                    if (accum_we) begin
                        accum_reg <= clear_accum_op ? 8'h00 : result; // RULE2
                    end
                    if (zero_we) begin
                        zero_reg <= zero_val;
                    end
                    if (watchdog_clear_op) begin
                        wdclr_reg <= 1'b1;                          // RULE9
                    end
                    if (skip_if_bit_one && take_bubble) begin
                        program_counter_reg <= program_counter_reg + 13'd1; // RULE8
                    end
                    if (call_op) begin
                        stack_reg[sp_reg] <= program_counter_reg;   // RULE10
                        sp_reg            <= sp_reg + 3'd1;
                    end
                    if (call_op || goto_op) begin
                        program_counter_reg <= {pc_upper_latch_reg[4:3], k11_fld}; // RULE10
                    end
                end
                default: begin
                    phase_reg <= PH_FETCH;
                end
            endcase
        end
    end

    // ****************************************************************
    // active-low timeout and power-down flags
    // ****************************************************************
    // nothing in this block puts the core to sleep, so power-down only ever sets
    always @(posedge mclk_i) begin
        if (rst_i) begin
            timeout_flag_n_reg   <= `MIE_RST_FLAG_N;
            powerdown_flag_n_reg <= `MIE_RST_FLAG_N;
            wdog_timeout_o       <= 1'b0;
        end else begin
            wdog_timeout_o <= wdog_timeout;
            // a timeout in the same cycle as the clear still leaves its mark
            if (wdog_timeout) begin
                timeout_flag_n_reg <= 1'b0;
            end else if (wdclr_reg) begin
                timeout_flag_n_reg   <= 1'b1;                       // RULE9
                powerdown_flag_n_reg <= 1'b1;                       // RULE9
            end
        end
    end

    // ****************************************************************
    // apb slave: one wait state, then data, ready and error
    // ****************************************************************
    always @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o           <= 1'b0;
            pslverr_o          <= 1'b0;
            prdata_o           <= 32'h0000_0000;
            run_reg            <= 1'b0;
            wden_reg           <= 1'b0;
            pc_upper_latch_reg <= `MIE_RST_LATCH;
            faddr_reg          <= 7'h00;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            // read data and error stand only in the ready cycle, zero otherwise
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_o) begin
                case (paddr_i)
                    `MIE_A_CTRL:   prdata_o <= {30'h0, wden_reg, run_reg};
                    `MIE_A_STATUS: prdata_o <= {29'h0, timeout_flag_n_reg,
                                                powerdown_flag_n_reg, zero_reg};
                    `MIE_A_ACCUM:  prdata_o <= {24'h0, accum_reg};
                    `MIE_A_PC:     prdata_o <= {19'h0, program_counter_reg};
                    `MIE_A_LATCH:  prdata_o <= {27'h0, pc_upper_latch_reg};
                    `MIE_A_STACK:  prdata_o <= {19'h0, stack_top};
                    `MIE_A_WDOG:   prdata_o <= {16'h0, wdog_prescale, wdog_count};
                    `MIE_A_FADDR:  prdata_o <= {25'h0, faddr_reg};
                    `MIE_A_FDATA:  prdata_o <= {24'h0, file_rdata};
                    default:       pslverr_o <= 1'b1;               // unmapped
                endcase
            end
            if (apb_wr) begin
                // writable control registers; read-only ones keep their value
                case (paddr_i)
                    `MIE_A_CTRL: begin
                        run_reg  <= pwdata_i[`MIE_CTRL_RUN];
                        wden_reg <= pwdata_i[`MIE_CTRL_WDEN];
                    end
                    `MIE_A_LATCH: pc_upper_latch_reg <= pwdata_i[4:0];
                    `MIE_A_FADDR: faddr_reg <= pwdata_i[6:0];
                    default: faddr_reg <= faddr_reg;
                endcase
            end
        end
    end
endmodule

// File: mie_defines.vh
// constants for the instruction execute block: fields, encodings, register map, resets
`ifndef MIE_DEFINES_VH
`define MIE_DEFINES_VH

// ****************************************************************
// instruction word fields
// ****************************************************************
`define MIE_IW_W          14
`define MIE_F_MSB         6
`define MIE_D_POS         7
`define MIE_B_LSB         7
`define MIE_B_MSB         9
`define MIE_K8_MSB        7
`define MIE_K11_MSB       10
`define MIE_PC_W          13

// ****************************************************************
// opcode patterns (compared under the masks below)
// ****************************************************************
`define MIE_NOP_WORD      14'h0000
`define MIE_WDCLR_WORD    14'h0064
`define MIE_MASK_BYTE     14'h3f00
`define MIE_MASK_CLR      14'h3f80
`define MIE_MASK_BIT      14'h3c00
`define MIE_MASK_JMP      14'h3800
`define MIE_CLEAR_ACCUM_OP_PAT      14'h0100
`define MIE_CLEAR_REG_OP_PAT      14'h0180
`define MIE_COMPLEMENT_REG_OP_PAT      14'h0900
`define MIE_DECREMENT_REG_OP_PAT      14'h0300
`define MIE_BTSS_PAT      14'h1c00
`define MIE_CALL_PAT      14'h2000
`define MIE_GOTO_PAT      14'h2800

// ****************************************************************
// apb register map (byte addresses)
// ****************************************************************
`define MIE_A_CTRL        8'h00
`define MIE_A_STATUS      8'h04
`define MIE_A_ACCUM       8'h08
`define MIE_A_PC          8'h0c
`define MIE_A_LATCH       8'h10
`define MIE_A_STACK       8'h14
`define MIE_A_WDOG        8'h18
`define MIE_A_FADDR       8'h1c
`define MIE_A_FDATA       8'h20

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MIE_CTRL_RUN      0
`define MIE_CTRL_WDEN     1
`define MIE_ST_Z          0
`define MIE_ST_PD         1
`define MIE_ST_TO         2
`define MIE_RST_PC        13'h0000
`define MIE_RST_BYTE      8'h00
`define MIE_RST_LATCH     5'h00
`define MIE_RST_FLAG_N    1'b1
`define MIE_STACK_DEPTH   8
`define MIE_PHASES        4

`endif

// File: mie_regfile.v
// file register array of 128 bytes, registered read, single write port
`timescale 1ns/100ps
module mie_regfile (
    input  wire       mclk_i,
    input  wire [6:0] rd_addr_i,
    output reg  [7:0] rd_data_o,
    input  wire       wr_en_i,
    input  wire [6:0] wr_addr_i,
    input  wire [7:0] wr_data_i
);
    reg [7:0] mem_reg [0:127];

    // read every cycle so a read always precedes a write back
    always @(posedge mclk_i) begin
        rd_data_o <= mem_reg[rd_addr_i];
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end
endmodule

// File: mie_watchdog.v
// watchdog counter with prescaler, synchronous clear and timeout pulse
`timescale 1ns/100ps
`include "mie_defines.vh"
module mie_watchdog (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire       enable_i,
    input  wire       clear_i,
    output reg  [7:0] count_o,
    output reg  [7:0] prescale_o,
    output reg        timeout_o
);
    // clear forces both stages to zero; overflow of the counter gives one pulse
    always @(posedge mclk_i) begin
        timeout_o <= 1'b0;
        if (rst_i || clear_i) begin
            count_o    <= `MIE_RST_BYTE;
            prescale_o <= `MIE_RST_BYTE;
        end else if (enable_i) begin
            prescale_o <= prescale_o + 8'h01;
            if (prescale_o == 8'hff) begin
                count_o <= count_o + 8'h01;
                if (count_o == 8'hff) begin
                    timeout_o <= 1'b1;
                end
            end
        end
    end
endmodule

// File: mie_core_monitor.sv
// checker for the apb handshake and fetch spacing at the core's ports
`timescale 1ns/100ps
module mie_core_monitor (
    input wire        mclk_i,
    input wire        rst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [12:0] prog_addr_o,
    input wire [13:0] prog_data_i,
    input wire        wdog_timeout_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // first access cycle still waiting, and whether its address is a mapped word
    wire acc_w = psel_i && penable_i && !pready_o;
    wire map_w = paddr_i <= 8'h20 && paddr_i[1:0] == 2'b00;
    a_ready_one_wait: assert property (acc_w |=> pready_o)
        else $error("ready did not follow the access phase");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held for more than one cycle");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
        else $error("ready outside an access phase");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data not zero outside ready");
    a_unmapped_err: assert property (acc_w && paddr_i > 8'h20 |=> pslverr_o)
        else $error("unmapped address without error");
    a_mapped_ok: assert property (acc_w && map_w |=> !pslverr_o)
        else $error("mapped address gave error");
    a_fetch_spacing: assert property ($changed(prog_addr_o) |=> $stable(prog_addr_o)[*3])
        else $error("fetches closer than four clocks");
    // main scenarios reached
    c_write: cover property (psel_i && penable_i && pready_o && pwrite_i);
    c_error: cover property (pslverr_o);
    c_fetch: cover property ($changed(prog_addr_o));
endmodule

// File: mie_prog_mem.sv
// program memory model: 8k words, read combinationally from the fetch address
`timescale 1ns/100ps
module mie_prog_mem (
    input  wire         mclk_i,
    input  wire  [12:0] addr_i,
    output logic [13:0] data_o
);
    logic [13:0] mem [0:8191];
    // every word is held and delivered whole, fourteen bits
    initial for (int i = 0; i < 8192; i++) mem[i] = 14'h0000;
    // answer within the cycle the address is presented
    assign data_o = mem[addr_i];
endmodule

// File: tb_top.sv
// testbench: apb register access and short programs run from the memory model
`timescale 1ns/100ps
`include "mie_defines.vh"
module tb_top;
    logic        mclk_i    = 1'b0;
    logic        rst_i     = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire  [12:0] prog_addr_o;
    wire  [13:0] prog_data_i;
    wire         wdog_timeout_o;
    int          n_fail    = 0;
    int          checks    = 0;
    int          cyc       = 0;
    int          t_last    = 0;
    int          n4        = 0;
    int          n8        = 0;
    logic        hit       = 1'b0;
    logic [12:0] last_pa   = 13'h0000;
    logic [31:0] rv;
    logic        ev;

    mie_core u_mie_core (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .wdog_timeout_o(wdog_timeout_o));
    mie_prog_mem u_mie_prog_mem (.mclk_i(mclk_i), .addr_i(prog_addr_o), .data_o(prog_data_i));

    // clock and run limit
    always #5 mclk_i = ~mclk_i;
    initial begin
        #1_000_000;
        n_fail++;
        $display("wrong value at %0t: run timed out", $time);
        test_done;
    end
    // gaps between fetch address changes, counted until the word after the call target (13'h1924) is seen
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (prog_addr_o !== last_pa) begin
            last_pa <= prog_addr_o;
            t_last  <= cyc;
            if (!hit && cyc - t_last == 8) n8 <= n8 + 1;
            if (!hit && cyc - t_last == 4) n4 <= n4 + 1;
            if (prog_addr_o === 13'h1924) hit <= 1'b1;
        end
    end

    task automatic test_done;
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error land in rv and ev
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rv = prdata_o;
        ev = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        cmp({31'h0, pready_o}, 32'h1);
    endtask
    task automatic setf(input logic [6:0] f, input logic [7:0] v);
        apb(1'b1, `MIE_A_FADDR, {25'h0, f});
        apb(1'b1, `MIE_A_FDATA, {24'h0, v});
    endtask
    task automatic getf(input logic [6:0] f);
        apb(1'b1, `MIE_A_FADDR, {25'h0, f});
        apb(1'b0, `MIE_A_FDATA, 32'h0000_0000);
    endtask
    task automatic ld(input logic [12:0] a, input logic [13:0] w);
        u_mie_prog_mem.mem[a] = w;
    endtask
    // start at word 0, stop once the closing loop word is fetched
    task automatic run(input logic [12:0] stop_at);
        int n;
        n = 0;
        apb(1'b1, `MIE_A_PC, 32'h0000_0000);
        apb(1'b1, `MIE_A_CTRL, 32'h0000_0001);
        while (prog_addr_o !== stop_at && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        cmp({19'h0, prog_addr_o}, {19'h0, stop_at});
        apb(1'b1, `MIE_A_CTRL, 32'h0000_0000);
    endtask

    task automatic t_reset;
        apb(1'b0, `MIE_A_STATUS, 32'h0000_0000);
        cmp(rv, 32'h0000_0006);
        apb(1'b0, 8'h40, 32'h0000_0000);
        cmp({rv[30:0], ev}, 32'h0000_0001);
        apb(1'b1, 8'h44, 32'h0000_00ff);
        cmp({31'h0, ev}, 32'h0000_0001);
    endtask
    task automatic t_byte_ops;
        setf(7'h10, 8'h5a);
        ld(0, `MIE_COMPLEMENT_REG_OP_PAT | 14'h0090);
        ld(1, `MIE_DECREMENT_REG_OP_PAT | 14'h0010);
        ld(2, `MIE_GOTO_PAT | 14'h0002);
        run(13'h0002);
        getf(7'h10);
        cmp(rv, 32'h0000_00a5);
        apb(1'b0, `MIE_A_ACCUM, 32'h0000_0000);
        cmp(rv, 32'h0000_00a4);
        apb(1'b0, `MIE_A_STATUS, 32'h0000_0000);
        cmp(rv, 32'h0000_0006);
    endtask
    task automatic t_zero_ops;
        setf(7'h11, 8'h01);
        setf(7'h12, 8'hff);
        setf(7'h7f, 8'h77);
        ld(0, `MIE_DECREMENT_REG_OP_PAT | 14'h0091);
        ld(1, `MIE_COMPLEMENT_REG_OP_PAT | 14'h0012);
        ld(2, `MIE_COMPLEMENT_REG_OP_PAT | 14'h0011);
        ld(3, `MIE_CLEAR_REG_OP_PAT | 14'h007f);
        ld(4, `MIE_GOTO_PAT | 14'h0004);
        run(13'h0004);
        getf(7'h11);
        cmp(rv, 32'h0000_0000);
        getf(7'h12);
        cmp(rv, 32'h0000_00ff);
        getf(7'h7f);
        cmp(rv, 32'h0000_0000);
        apb(1'b0, `MIE_A_ACCUM, 32'h0000_0000);
        cmp(rv, 32'h0000_00ff);
        apb(1'b0, `MIE_A_STATUS, 32'h0000_0000);
        cmp(rv, 32'h0000_0007);
    endtask
    task automatic t_wdog_timeout;
        int n;
        n = 0;
        apb(1'b1, `MIE_A_CTRL, 32'h0000_0002);
        while (wdog_timeout_o !== 1'b1 && n < 70000) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (600) @(posedge mclk_i);
        apb(1'b1, `MIE_A_CTRL, 32'h0000_0000);
        apb(1'b0, `MIE_A_STATUS, 32'h0000_0000);
        cmp(rv, 32'h0000_0003);
        apb(1'b0, `MIE_A_WDOG, 32'h0000_0000);
        cmp({31'h0, rv[7:0] != 8'h00}, 32'h0000_0001);
    endtask
    task automatic t_skip_call;
        int b4, b8;
        setf(7'h14, 8'h55);
        setf(7'h15, 8'hfe);
        setf(7'h16, 8'h99);
        apb(1'b1, `MIE_A_LATCH, 32'h0000_0018);
        ld(0, `MIE_DECREMENT_REG_OP_PAT | 14'h0012);
        ld(1, `MIE_CLEAR_ACCUM_OP_PAT);
        ld(2, `MIE_BTSS_PAT | 14'h0192);
        ld(3, `MIE_CLEAR_REG_OP_PAT | 14'h0014);
        ld(4, `MIE_BTSS_PAT | 14'h0015);
        ld(5, `MIE_CLEAR_REG_OP_PAT | 14'h0016);
        ld(6, `MIE_WDCLR_WORD);
        ld(7, `MIE_CALL_PAT | 14'h0123);
        ld(13'h1923, `MIE_NOP_WORD);
        ld(13'h1924, `MIE_GOTO_PAT | 14'h0124);
        b4 = n4;
        b8 = n8;
        run(13'h1924);
        getf(7'h14);
        cmp(rv, 32'h0000_0055);
        getf(7'h16);
        cmp(rv, 32'h0000_0000);
        apb(1'b0, `MIE_A_ACCUM, 32'h0000_0000);
        cmp(rv, 32'h0000_0000);
        apb(1'b0, `MIE_A_STATUS, 32'h0000_0000);
        cmp(rv, 32'h0000_0007);
        apb(1'b0, `MIE_A_WDOG, 32'h0000_0000);
        cmp(rv, 32'h0000_0000);
        apb(1'b0, `MIE_A_STACK, 32'h0000_0000);
        cmp(rv, 32'h0000_0008);
        cmp(n8 - b8, 32'h0000_0002);
        cmp(n4 - b4, 32'h0000_0006);
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset;
        t_byte_ops;
        t_zero_ops;
        t_wdog_timeout;
        t_skip_call;
        test_done;
    end
endmodule

bind mie_core mie_core_monitor u_mie_core_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .wdog_timeout_o(wdog_timeout_o));
